// >>> shared/fmd_consts.svh
`ifndef FMD_CONSTS_SVH
`define FMD_CONSTS_SVH

// clock rate and human timing
`define FMD_CLK_HZ 32'd25000000
`define FMD_LONG_TIME_MS 32'd1000
`define FMD_IDLE_TIME_S 32'd120

// fault codes shown while in the error state
`define FMD_CODE_NO_NETWORK 16'h0002
`define FMD_CODE_BAD_SERIAL 16'h0009
`define FMD_CODE_OVERCURRENT 16'h000a
`define FMD_CODE_BAD_NODE 16'h000f
`define FMD_CODE_OVERVOLTAGE 16'h0100
`define FMD_CODE_UNDERVOLTAGE 16'h0102
`define FMD_CODE_USER_BASE 16'hc000
`define FMD_CODE_USER_MIN_LOW 8'h01

// numbered led masks, bit n-1 is led n
`define FMD_LEDS_NO_NETWORK 16'h0002
`define FMD_LEDS_BAD_SERIAL 16'h0009
`define FMD_LEDS_OVERCURRENT 16'h000a
`define FMD_LEDS_BAD_NODE 16'h000f
`define FMD_LEDS_OVERVOLTAGE 16'h0100
`define FMD_LEDS_UNDERVOLTAGE 16'h0102
`define FMD_LEDS_USER_MARK 16'hc000
`define FMD_LEDS_CONFIG 16'h0001

// menu led patterns and reset values
`define FMD_MENU_ALL 6'h3f
`define FMD_LEDS_OFF 16'h0000
`define FMD_MENU_OFF 6'h00
`define FMD_CODE_NONE 16'h0000
`define FMD_NODE_FIRST 4'h0

`endif

// >>> shared/fmd_pkg.sv
package fmd_pkg;
    // top level menus in button order
    typedef enum logic [2:0] {
        MENU_NODE, MENU_IO, MENU_VOLT, MENU_MEM, MENU_RADIO, MENU_CAN
    } fmd_menu_t;
    // menu depth
    typedef enum logic [1:0] {LVL_TOP, LVL_SECOND, LVL_THIRD} fmd_level_t;
    // what the display is showing
    typedef enum logic [1:0] {MODE_MENU, MODE_CONFIG, MODE_FATAL} fmd_mode_t;
endpackage

// >>> hdl/fmd_button.sv
`include "fmd_consts.svh"

// sorts a capacitive button into brief and long presses
module fmd_button #(
    parameter int unsigned LONG_CYCLES = `FMD_LONG_TIME_MS * (`FMD_CLK_HZ / 32'd1000)
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // raw pin
    input wire logic i_button,
    // classified presses
    output logic o_pressed,
    output logic o_short_press,
    output logic o_long_press
);
    localparam int CW = $clog2(LONG_CYCLES + 1);

    logic sync1, sync2; // pin synchroniser, sync1 only feeds sync2
    logic pressed, next_pressed; // last sampled level
    logic [CW-1:0] hold, next_hold; // cycles the button has been held
    logic long_done, next_long_done; // long press already reported this hold
    logic short_p, next_short_p;
    logic long_p, next_long_p;

    // the long press fires while still held, so the operator sees the level change at 1 s
    always_comb begin
        next_pressed = sync2;
        next_hold = hold;
        next_long_done = long_done;
        next_short_p = 1'b0;
        next_long_p = 1'b0;
        if (sync2) begin
            if (!long_done) begin
                if (hold == CW'(LONG_CYCLES - 1)) begin
                    next_long_p = 1'b1;
                    next_long_done = 1'b1;
                end else begin
                    next_hold = hold + CW'(1);
                end
            end
        end else begin
            // release before the threshold counts as brief
            next_short_p = pressed && !long_done;
            next_hold = '0;
            next_long_done = 1'b0;
        end
    end

    // registers, frozen while the enable is low
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            pressed <= 1'b0;
            hold <= '0;
            long_done <= 1'b0;
            short_p <= 1'b0;
            long_p <= 1'b0;
        end else if (i_clk_en) begin
            sync1 <= i_button;
            sync2 <= sync1;
            pressed <= next_pressed;
            hold <= next_hold;
            long_done <= next_long_done;
            short_p <= next_short_p;
            long_p <= next_long_p;
        end
    end

    assign o_pressed = pressed;
    assign o_short_press = short_p;
    assign o_long_press = long_p;
endmodule

// >>> hdl/fmd_display.sv
// What this block does
// - fatal fault: error state, I/O and comms off
// - error state: six menu LEDs red plus code
// - config faults show codes 0002, 0009, 000F
// - overcurrent shows code 000A, LEDs 2,4
// - overvoltage 0100 LED 9, undervoltage 0102
// - config mode: six menu LEDs, LED 1 orange
// - top level green, brief press advances menu
// - one second hold is a long press
// - second level shows menu LED red
// - long presses step levels, then wrap top
// - U and MEM sub-levels: brief press picks next node
// - third level only U and CAN, orange
// - sub-level brief press keeps selected menu
// - node menu after reset and long idle
`include "fmd_consts.svh"

module fmd_display
    import fmd_pkg::*;
#(
    parameter int unsigned LONG_CYCLES = `FMD_LONG_TIME_MS * (`FMD_CLK_HZ / 32'd1000),
    parameter int unsigned IDLE_CYCLES = `FMD_IDLE_TIME_S * `FMD_CLK_HZ,
    parameter int unsigned NODE_COUNT = 16
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // operator button pin
    input wire logic i_button,
    // fault sources, same clock domain, level
    input wire logic i_missing_network_identity_fault,
    input wire logic i_bad_serial_setting_fault,
    input wire logic i_bad_node_setting_fault,
    input wire logic i_output_overcurrent_fault,
    input wire logic i_supply_overvoltage_fault,
    input wire logic i_supply_undervoltage_fault,
    input wire logic i_user_fatal_fault,
    input wire logic [7:0] i_user_fault_code,
    // configuration mode level
    input wire logic i_config_mode,
    // menu page content for the numbered leds
    input wire logic [15:0] i_page_red,
    input wire logic [15:0] i_page_green,
    // shutdown controls and latched fault code
    output logic o_io_off,
    output logic o_comm_off,
    output logic [15:0] o_fault_code,
    // leds, orange is red and green together
    output logic [5:0] o_menu_red,
    output logic [5:0] o_menu_green,
    output logic [15:0] o_num_red,
    output logic [15:0] o_num_green,
    // menu position for the page source
    output fmd_pkg::fmd_menu_t o_menu,
    output fmd_pkg::fmd_level_t o_level,
    output logic [3:0] o_node,
    output logic o_info_step
);
    logic short_press, long_press, pressed; // classified button events
    fmd_mode_t mode, next_mode; // display mode
    logic [15:0] code, next_code; // latched fault code
    fmd_menu_t menu, next_menu; // selected top level menu
    fmd_level_t level, next_level; // current menu depth
    logic [3:0] node, next_node; // node being looked at
    logic info_step, next_info_step; // page should show next item
    logic [31:0] idle, next_idle; // cycles since the button was touched
    logic [5:0] mred, next_mred, mgrn, next_mgrn;
    logic [15:0] nred, next_nred, ngrn, next_ngrn;
    logic any_fault;

    // brief and long press detection
    fmd_button #(.LONG_CYCLES(LONG_CYCLES)) u_button (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_button(i_button),
        .o_pressed(pressed),
        .o_short_press(short_press),
        .o_long_press(long_press)
    );

    // first matching source wins when several faults arrive together
    function automatic logic [15:0] pick_code(input logic [6:0] f, input logic [7:0] user);
        logic [7:0] low;
        low = (user == 8'h00) ? `FMD_CODE_USER_MIN_LOW : user;
        if (f[0]) pick_code = `FMD_CODE_NO_NETWORK;
        else if (f[1]) pick_code = `FMD_CODE_BAD_SERIAL;
        else if (f[2]) pick_code = `FMD_CODE_BAD_NODE;
        else if (f[3]) pick_code = `FMD_CODE_OVERCURRENT;
        else if (f[4]) pick_code = `FMD_CODE_OVERVOLTAGE;
        else if (f[5]) pick_code = `FMD_CODE_UNDERVOLTAGE;
        else pick_code = `FMD_CODE_USER_BASE | {8'h00, low};
    endfunction

    // numbered leds that spell a fault code
    function automatic logic [15:0] code_leds(input logic [15:0] c);
        unique case (c)
            `FMD_CODE_NO_NETWORK: code_leds = `FMD_LEDS_NO_NETWORK;
            `FMD_CODE_BAD_SERIAL: code_leds = `FMD_LEDS_BAD_SERIAL;
            `FMD_CODE_BAD_NODE: code_leds = `FMD_LEDS_BAD_NODE;
            `FMD_CODE_OVERCURRENT: code_leds = `FMD_LEDS_OVERCURRENT;
            `FMD_CODE_OVERVOLTAGE: code_leds = `FMD_LEDS_OVERVOLTAGE;
            `FMD_CODE_UNDERVOLTAGE: code_leds = `FMD_LEDS_UNDERVOLTAGE;
            default: code_leds = `FMD_LEDS_USER_MARK | {8'h00, c[7:0]};
        endcase
    endfunction

    // next top level menu in the ring
    function automatic fmd_menu_t menu_succ(input fmd_menu_t m);
        menu_succ = (m == MENU_CAN) ? MENU_NODE : fmd_menu_t'(m + 3'd1);
    endfunction

    // menus whose sub-levels browse other nodes
    function automatic logic node_page(input fmd_menu_t m, input fmd_level_t l);
        node_page = (m == MENU_VOLT && l != LVL_TOP) || (m == MENU_MEM && l == LVL_SECOND);
    endfunction

    assign any_fault = i_missing_network_identity_fault | i_bad_serial_setting_fault
        | i_bad_node_setting_fault | i_output_overcurrent_fault
        | i_supply_overvoltage_fault | i_supply_undervoltage_fault | i_user_fatal_fault;

    // mode: the error state is sticky until reset, a fault is never dropped silently
    always_comb begin
        next_mode = mode;
        next_code = code;
        unique case (mode)
            MODE_MENU, MODE_CONFIG: begin
                if (any_fault) begin
                    next_mode = MODE_FATAL;
                    next_code = pick_code({i_user_fatal_fault, i_supply_undervoltage_fault,
                        i_supply_overvoltage_fault, i_output_overcurrent_fault,
                        i_bad_node_setting_fault, i_bad_serial_setting_fault,
                        i_missing_network_identity_fault}, i_user_fault_code);
                end else begin
                    next_mode = i_config_mode ? MODE_CONFIG : MODE_MENU;
                end
            end
            MODE_FATAL: next_mode = MODE_FATAL;
        endcase
    end

    // mode registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= MODE_MENU;
            code <= `FMD_CODE_NONE;
        end else if (i_clk_en) begin
            mode <= next_mode;
            code <= next_code;
        end
    end

    // menu walk; presses are dropped outright while a pattern is shown
    always_comb begin
        next_menu = menu;
        next_level = level;
        next_node = node;
        next_info_step = 1'b0;
        next_idle = pressed ? 32'h0000_0000 : idle + 32'h0000_0001;
        if (mode != MODE_MENU) begin
            next_idle = idle;
        end else if (!pressed && idle >= IDLE_CYCLES - 1) begin
            next_menu = MENU_NODE;
            next_level = LVL_TOP;
            next_node = `FMD_NODE_FIRST;
            next_idle = 32'h0000_0000;
        end else if (long_press) begin
            next_node = `FMD_NODE_FIRST;
            unique case (level)
                LVL_TOP: next_level = LVL_SECOND;
                LVL_SECOND: begin
                    // only U and CAN go one deeper, the rest wrap home
                    if (menu == MENU_VOLT || menu == MENU_CAN) begin
                        next_level = LVL_THIRD;
                    end else begin
                        next_level = LVL_TOP;
                    end
                end
                LVL_THIRD: next_level = LVL_TOP;
            endcase
        end else if (short_press) begin
            if (level == LVL_TOP) begin
                next_menu = menu_succ(menu);
            end else begin
                next_info_step = 1'b1;
                if (node_page(menu, level)) begin
                    next_node = (node == 4'(NODE_COUNT - 1)) ? `FMD_NODE_FIRST
                        : node + 4'h1;
                end
            end
        end
    end

    // menu registers, node menu at top level after reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            menu <= MENU_NODE;
            level <= LVL_TOP;
            node <= `FMD_NODE_FIRST;
            info_step <= 1'b0;
            idle <= 32'h0000_0000;
        end else if (i_clk_en) begin
            menu <= next_menu;
            level <= next_level;
            node <= next_node;
            info_step <= next_info_step;
            idle <= next_idle;
        end
    end

    // led picture; fault beats config beats the normal menu
    always_comb begin
        next_mred = `FMD_MENU_OFF;
        next_mgrn = `FMD_MENU_OFF;
        next_nred = i_page_red;
        next_ngrn = i_page_green;
        unique case (mode)
            MODE_FATAL: begin
                next_mred = `FMD_MENU_ALL;
                next_nred = code_leds(code);
                next_ngrn = `FMD_LEDS_OFF;
            end
            MODE_CONFIG: begin
                next_mred = `FMD_MENU_ALL;
                next_mgrn = `FMD_MENU_ALL;
                next_nred = `FMD_LEDS_CONFIG;
                next_ngrn = `FMD_LEDS_CONFIG;
            end
            MODE_MENU: begin
                unique case (level)
                    LVL_TOP: next_mgrn[menu] = 1'b1;
                    LVL_SECOND: next_mred[menu] = 1'b1;
                    LVL_THIRD: begin
                        next_mred[menu] = 1'b1;
                        next_mgrn[menu] = 1'b1;
                    end
                endcase
            end
        endcase
    end

    // led output registers, dark during reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mred <= `FMD_MENU_OFF;
            mgrn <= `FMD_MENU_OFF;
            nred <= `FMD_LEDS_OFF;
            ngrn <= `FMD_LEDS_OFF;
        end else if (i_clk_en) begin
            mred <= next_mred;
            mgrn <= next_mgrn;
            nred <= next_nred;
            ngrn <= next_ngrn;
        end
    end

    assign o_io_off = (mode == MODE_FATAL);
    assign o_comm_off = (mode == MODE_FATAL);
    assign o_fault_code = code;
    assign o_menu_red = mred;
    assign o_menu_green = mgrn;
    assign o_num_red = nred;
    assign o_num_green = ngrn;
    assign o_menu = menu;
    assign o_level = level;
    assign o_node = node;
    assign o_info_step = info_step;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    fatal_entry_a: assert property (
        i_clk_en && any_fault |=> mode == MODE_FATAL && o_io_off && o_comm_off)
        else $error("fault did not enter error state");
    fatal_leds_a: assert property (
        mode == MODE_FATAL && i_clk_en |=> o_menu_red == 6'h3f && o_menu_green == 6'h00
        && o_num_green == 16'h0000)
        else $error("error pattern menu leds wrong");
    network_code_a: assert property (
        mode != MODE_FATAL && i_missing_network_identity_fault && i_clk_en ##1 i_clk_en
        |=> o_fault_code == 16'h0002 && o_num_red == 16'h0002)
        else $error("network fault code wrong");
    overcurrent_code_a: assert property (
        mode != MODE_FATAL && i_output_overcurrent_fault && !i_missing_network_identity_fault
        && !i_bad_serial_setting_fault && !i_bad_node_setting_fault && i_clk_en ##1 i_clk_en
        |=> o_fault_code == 16'h000a && o_num_red == 16'h000a)
        else $error("overcurrent code wrong");
    undervolt_code_a: assert property (
        mode != MODE_FATAL && any_fault && i_supply_undervoltage_fault
        && !i_missing_network_identity_fault && !i_bad_serial_setting_fault
        && !i_bad_node_setting_fault && !i_output_overcurrent_fault
        && !i_supply_overvoltage_fault && i_clk_en ##1 i_clk_en
        |=> o_fault_code == 16'h0102 && o_num_red == 16'h0102)
        else $error("undervoltage code wrong");
    user_leds_a: assert property (
        mode == MODE_FATAL && code[15:8] == 8'hc0 && i_clk_en
        |=> o_num_red[15:14] == 2'b11 && o_num_red[7:0] == o_fault_code[7:0]
        && o_fault_code[7:0] != 8'h00)
        else $error("user fatal leds wrong");
    config_pattern_a: assert property (
        mode == MODE_CONFIG && i_clk_en |=> o_menu_red == 6'h3f && o_menu_green == 6'h3f
        && o_num_red == 16'h0001 && o_num_green == 16'h0001)
        else $error("config pattern wrong");
    top_advance_a: assert property (
        mode == MODE_MENU && level == LVL_TOP && short_press && !pressed && i_clk_en
        && idle < IDLE_CYCLES - 1 |=> menu == menu_succ($past(menu)))
        else $error("brief press did not advance menu");
    second_red_a: assert property (
        mode == MODE_MENU && level == LVL_SECOND && i_clk_en
        |=> o_menu_red[$past(menu)] && !o_menu_green[$past(menu)])
        else $error("second level led not red");
    third_only_a: assert property (
        level == LVL_THIRD |-> menu == MENU_VOLT || menu == MENU_CAN)
        else $error("third level in wrong menu");
    sub_keeps_menu_a: assert property (
        level != LVL_TOP && short_press && !long_press |=> menu == $past(menu))
        else $error("sub-level press changed menu");
    pattern_frozen_a: assert property (
        mode != MODE_MENU |=> menu == $past(menu) && level == $past(level)
        && node == $past(node))
        else $error("menu moved under pattern");

    reach_third_c: cover property (level == LVL_SECOND ##1 level == LVL_THIRD);
    wrap_top_c: cover property (level == LVL_THIRD ##1 level == LVL_TOP);
    fatal_c: cover property (mode == MODE_MENU ##1 mode == MODE_FATAL);
    node_step_c: cover property (node == 4'h0 ##1 node == 4'h1);
endmodule

// >>> sim/fmd_operator.sv
// behavioural operator touching the capacitive pad
module fmd_operator (
    // clock from the bench
    input wire logic i_ref_clk,
    // pad level towards the display block
    output logic o_button
);
    timeunit 1ns;
    timeprecision 1ps;

    // untouched pad reads low
    initial o_button = 1'b0;

    // touch the pad for a number of clock cycles, then let go
    // a hold of the long count or more means one level down, or back to the top from a menu's last level
    task automatic press(input int unsigned hold);
        @(posedge i_ref_clk);
        #1;
        o_button = 1'b1;
        repeat (hold) @(posedge i_ref_clk);
        #1;
        o_button = 1'b0;
        // brief presses are only known after release, so leave room to land
        repeat (10) @(posedge i_ref_clk);
    endtask
endmodule

// >>> sim/tb_fmd_display.sv
`include "fmd_consts.svh"

`define FMD_TB_CHECK(got, exp, what) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("unexpected at %0t ns: %s", $time, what); \
        end \
    end

// self-checking bench for the fault and menu display
module tb_fmd_display;
    timeunit 1ns;
    timeprecision 1ps;
    import fmd_pkg::*;

    // shortened counts keep the run short
    localparam int unsigned LONG = 8;
    localparam int unsigned IDLE = 200;
    localparam int unsigned NODES = 4;
    localparam logic [15:0] PAGE_R = 16'h00f0;
    localparam logic [15:0] PAGE_G = 16'h0f00;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic btn;
    logic [6:0] fault_vec = 7'h00; // network, serial, node, current, over, under, user
    logic [7:0] user_code = 8'h00;
    logic cfg = 1'b0;
    logic clk_en = 1'b1; // clock enable, dropped once to check that state freezes
    logic io_off, comm_off, info_step;
    logic [15:0] fault_code, num_red, num_green;
    logic [5:0] menu_red, menu_green;
    fmd_menu_t menu;
    fmd_level_t level;
    logic [3:0] node;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_steps = 0;

    // free running 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    fmd_operator u_op (.i_ref_clk(clk), .o_button(btn));

    fmd_display #(.LONG_CYCLES(LONG), .IDLE_CYCLES(IDLE), .NODE_COUNT(NODES)) u_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_button(btn),
        .i_missing_network_identity_fault(fault_vec[0]),
        .i_bad_serial_setting_fault(fault_vec[1]),
        .i_bad_node_setting_fault(fault_vec[2]),
        .i_output_overcurrent_fault(fault_vec[3]),
        .i_supply_overvoltage_fault(fault_vec[4]),
        .i_supply_undervoltage_fault(fault_vec[5]),
        .i_user_fatal_fault(fault_vec[6]), .i_user_fault_code(user_code),
        .i_config_mode(cfg), .i_page_red(PAGE_R), .i_page_green(PAGE_G),
        .o_io_off(io_off), .o_comm_off(comm_off), .o_fault_code(fault_code),
        .o_menu_red(menu_red), .o_menu_green(menu_green),
        .o_num_red(num_red), .o_num_green(num_green),
        .o_menu(menu), .o_level(level), .o_node(node), .o_info_step(info_step)
    );

    // count one-cycle sub-level pulses as they stand
    always @(posedge clk) begin
        if (info_step === 1'b1) n_steps++;
    end

    // waits n edges, so inputs set right after it land one nanosecond after the edge
    task automatic tick(input int unsigned n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        tick(4);
        rst_n = 1'b1;
        tick(2);
    endtask

    task automatic brief();
        u_op.press(LONG - 2);
    endtask

    task automatic held();
        u_op.press(LONG + 4);
    endtask

    task automatic expect_pos(input fmd_menu_t m, input fmd_level_t l, input logic [3:0] n);
        `FMD_TB_CHECK({menu, level, node}, {m, l, n}, "menu position")
    endtask

    task automatic expect_leds(input logic [5:0] r, input logic [5:0] g);
        `FMD_TB_CHECK({menu_red, menu_green}, {r, g}, "menu leds")
    endtask

    task automatic t_start();
        expect_pos(MENU_NODE, LVL_TOP, 4'h0);
        expect_leds(6'h00, 6'h01);
        `FMD_TB_CHECK({num_red, num_green}, {PAGE_R, PAGE_G}, "page shown")
        `FMD_TB_CHECK({io_off, comm_off, fault_code}, 18'h0, "no fault")
        $display("start test done");
    endtask

    task automatic t_top_cycle();
        for (int k = 1; k <= 6; k++) begin
            brief();
            expect_pos(fmd_menu_t'(k % 6), LVL_TOP, 4'h0);
            expect_leds(6'h00, 6'(6'h01 << (k % 6)));
        end
        // a press while the enable is low must leave no trace, the synchroniser is frozen too
        clk_en = 1'b0;
        brief();
        clk_en = 1'b1;
        tick(4);
        expect_pos(MENU_NODE, LVL_TOP, 4'h0);
        `FMD_TB_CHECK(n_steps, 0, "no step at top")
        $display("top cycle test done");
    endtask

    task automatic t_levels();
        brief();
        brief();
        held();
        expect_pos(MENU_VOLT, LVL_SECOND, 4'h0);
        expect_leds(6'h04, 6'h00);
        brief();
        expect_pos(MENU_VOLT, LVL_SECOND, 4'h1);
        held();
        expect_pos(MENU_VOLT, LVL_THIRD, 4'h0);
        expect_leds(6'h04, 6'h04);
        brief();
        expect_pos(MENU_VOLT, LVL_THIRD, 4'h1);
        held();
        expect_pos(MENU_VOLT, LVL_TOP, 4'h0);
        expect_leds(6'h00, 6'h04);
        brief();
        held();
        // node index wraps at the node count
        for (int k = 1; k <= NODES; k++) begin
            brief();
            expect_pos(MENU_MEM, LVL_SECOND, 4'(k % NODES));
        end
        held();
        expect_pos(MENU_MEM, LVL_TOP, 4'h0);
        brief();
        brief();
        held();
        held();
        expect_pos(MENU_CAN, LVL_THIRD, 4'h0);
        // this page does not browse nodes, so a brief press only steps the page
        brief();
        expect_pos(MENU_CAN, LVL_THIRD, 4'h0);
        held();
        expect_pos(MENU_CAN, LVL_TOP, 4'h0);
        `FMD_TB_CHECK(n_steps, 3 + NODES, "sub-level steps")
        $display("levels test done");
    endtask

    task automatic t_config();
        cfg = 1'b1;
        tick(3);
        expect_leds(`FMD_MENU_ALL, `FMD_MENU_ALL);
        `FMD_TB_CHECK({num_red, num_green}, {2{`FMD_LEDS_CONFIG}}, "config leds")
        held();
        brief();
        expect_pos(MENU_CAN, LVL_TOP, 4'h0);
        cfg = 1'b0;
        tick(3);
        expect_leds(6'h00, 6'h20);
        $display("config test done");
    endtask

    task automatic t_idle();
        brief();
        tick(IDLE - 30);
        expect_pos(MENU_NODE, LVL_TOP, 4'h0);
        brief();
        tick(IDLE - 30);
        expect_pos(MENU_IO, LVL_TOP, 4'h0);
        tick(50);
        expect_pos(MENU_NODE, LVL_TOP, 4'h0);
        $display("idle test done");
    endtask

    task automatic t_faults();
        logic [6:0] vecs [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h40, 7'h21};
        logic [15:0] codes [9] = '{`FMD_CODE_NO_NETWORK, `FMD_CODE_BAD_SERIAL,
            `FMD_CODE_BAD_NODE, `FMD_CODE_OVERCURRENT, `FMD_CODE_OVERVOLTAGE,
            `FMD_CODE_UNDERVOLTAGE, 16'hc05a, 16'hc001, `FMD_CODE_NO_NETWORK};
        logic [15:0] masks [9] = '{16'h0002, 16'h0009, 16'h000f, 16'h000a, 16'h0100,
            16'h0102, 16'hc05a, 16'hc001, 16'h0002};
        // last entry raises two faults at once, the network fault must win over undervoltage
        for (int k = 0; k < 9; k++) begin
            do_reset();
            user_code = (k == 7) ? 8'h00 : 8'h5a;
            fault_vec = vecs[k];
            tick(3);
            `FMD_TB_CHECK({io_off, comm_off}, 2'b11, "shutdown")
            `FMD_TB_CHECK(fault_code, codes[k], "fault code")
            expect_leds(`FMD_MENU_ALL, 6'h00);
            `FMD_TB_CHECK({num_red, num_green}, {masks[k], 16'h0}, "fault leds")
            fault_vec = 7'h00;
            cfg = 1'b1;
            brief();
            held();
            expect_pos(MENU_NODE, LVL_TOP, 4'h0);
            expect_leds(`FMD_MENU_ALL, 6'h00);
            `FMD_TB_CHECK({io_off, fault_code}, {1'b1, codes[k]}, "sticky")
            cfg = 1'b0;
        end
        $display("fault test done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset();
        t_start();
        t_top_cycle();
        t_levels();
        t_config();
        t_idle();
        t_faults();
        final_report();
    end

    // the whole sequence needs some 1400 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        final_report();
    end
endmodule
